//--- hw/sccs_clock_ctrl.sv
// sccs_clock_ctrl: high-speed and internal clock source control,
// main/peripheral source selection and cpu clock divider.
// assumes hs_clk_in is synchronous to sys_clk and slower than half
// its rate; the internal oscillator is modelled by a divider.
`timescale 1ns/1ps
`default_nettype none

module sccs_clock_ctrl #(
  parameter int unsigned INT_DIV        = 6,   // sys_clk cycles per internal tick
  parameter int unsigned INT_SETTLE_CYC = 64   // internal accuracy settle time
) (
  input  wire  logic                 sys_clk,
  input  wire  logic                 arst_n,
  input  wire  logic [2:0]           reg_addr,
  input  wire  logic [7:0]           reg_wdata,
  input  wire  logic                 reg_wr,
  input  wire  logic                 reg_rd,
  output logic [7:0]                 reg_rdata,
  input  wire  logic                 hs_clk_in,
  input  wire  logic                 stop_exec,
  input  wire  logic                 stop_release,
  output sccs_pkg::sccs_clk_en_t     clk_en,
  output sccs_pkg::sccs_pin_ctl_t    pin_ctl,
  output logic [2:0]                 settle_time_select,
  output logic                       stop_mode
);

  ////////////////////////////////////////////////////////////////////
  // helpers

  // low bits of the divider count that must be zero for a cpu tick
  function automatic logic [3:0] div_mask(input logic [2:0] code);
    logic [3:0] m;
    m = 4'h0;
    unique case (code)
      3'h0:    m = 4'h0;
      3'h1:    m = 4'h1;
      3'h2:    m = 4'h3;
      3'h3:    m = 4'h7;
      default: m = 4'hf;
    endcase
    return m;
  endfunction : div_mask

  ////////////////////////////////////////////////////////////////////
  // declarations

  logic       ext_sel_r;
  logic       pin_mode_r;
  logic       gain_r;
  logic       gain_locked_r;
  logic       hs_stop_r;
  logic       hs_path_r;
  logic       main_sel_r;
  logic [2:0] div_code_r;
  logic [2:0] div_act_r;
  logic       int_stop_r;
  logic       int_settled_r;
  logic [2:0] settle_sel_r;
  logic [7:0] settle_cnt_r;
  logic       stop_mode_r;
  logic       hs_prev_r;
  logic [7:0] int_div_r;
  logic [7:0] int_settle_r;
  logic [7:0] hold_cnt_r;
  logic       hold_ext_r;
  logic [3:0] cpu_cnt_r;
  logic [7:0] rdata_r;
  sccs_pkg::sccs_main_state_t ms_r;
  sccs_pkg::sccs_main_state_t ms_nxt;
  sccs_pkg::sccs_clk_en_t     clk_en_r;
  sccs_pkg::sccs_pin_ctl_t    pin_ctl_r;

  logic hs_run;
  logic int_run;
  logic hs_tick;
  logic int_tick;
  logic main_tick;
  logic periph_tick;
  logic main_on_hs;
  logic want_hs;
  logic cpu_tick;
  logic hold_active;
  logic wr_osc;
  logic wr_hs;
  logic wr_main;
  logic wr_cpu;
  logic wr_int;
  logic wr_sset;
  logic gain_rise;

  ////////////////////////////////////////////////////////////////////
  // source activity and ticks

  // hs runs only with pins in clock mode, not stopped, not in stop
  assign hs_run = pin_mode_r & ~hs_stop_r & ~stop_mode_r;
  assign int_run = ~int_stop_r & ~stop_mode_r;
  assign hs_tick = hs_run & hs_clk_in & ~hs_prev_r;
  assign int_tick = int_run && (int_div_r == 8'(INT_DIV - 1));

  assign main_on_hs = (ms_r == sccs_pkg::MS_HS) || (ms_r == sccs_pkg::MS_TO_INT);
  assign want_hs = hs_path_r & main_sel_r & hs_run;
  assign main_tick = main_on_hs ? hs_tick : int_tick;
  // peripheral follows hs whenever path bit is set; hs main implies it
  assign periph_tick = (hs_path_r | main_on_hs) ? hs_tick : int_tick;

  assign hold_active = (hold_cnt_r != 8'h0);
  assign cpu_tick = main_tick && ((cpu_cnt_r & div_mask(div_act_r)) == 4'h0);

  // register strobes
  assign wr_osc  = reg_wr && (reg_addr == sccs_pkg::OFF_OSC_MODE);
  assign wr_hs   = reg_wr && (reg_addr == sccs_pkg::OFF_HS_CTRL);
  assign wr_main = reg_wr && (reg_addr == sccs_pkg::OFF_MAIN_MODE);
  assign wr_cpu  = reg_wr && (reg_addr == sccs_pkg::OFF_CPU_CTRL);
  assign wr_int  = reg_wr && (reg_addr == sccs_pkg::OFF_INT_MODE);
  assign wr_sset = reg_wr && (reg_addr == sccs_pkg::OFF_SETTLE_SEL);
  assign gain_rise = wr_osc && !gain_locked_r && !gain_r && reg_wdata[sccs_pkg::BIT_GAIN];

  ////////////////////////////////////////////////////////////////////
  // oscillator mode register

  // pin modes are not guarded: software keeps them while hs runs
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_sel_r  <= 1'b0;
      pin_mode_r <= 1'b0;
    end else if (wr_osc) begin
      ext_sel_r  <= reg_wdata[sccs_pkg::BIT_EXT_SEL];
      pin_mode_r <= reg_wdata[sccs_pkg::BIT_PIN_MODE];
    end
  end

  // gain may move once; a write of the same value does not use it up
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gain_r        <= 1'b0;
      gain_locked_r <= 1'b0;
    end else if (wr_osc && !gain_locked_r &&
                 (reg_wdata[sccs_pkg::BIT_GAIN] != gain_r)) begin
      gain_r        <= reg_wdata[sccs_pkg::BIT_GAIN];
      gain_locked_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stop controls, selection and divider registers

  // a stop that would kill the clock the cpu runs on is dropped
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_stop_r  <= 1'b1;
      int_stop_r <= 1'b0;
    end else begin
      if (wr_hs && !(reg_wdata[sccs_pkg::BIT_HS_STOP] && main_on_hs)) begin
        hs_stop_r <= reg_wdata[sccs_pkg::BIT_HS_STOP];
      end
      if (wr_int && !(reg_wdata[sccs_pkg::BIT_INT_STOP] && !main_on_hs)) begin
        int_stop_r <= reg_wdata[sccs_pkg::BIT_INT_STOP];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_path_r    <= 1'b0;
      main_sel_r   <= 1'b0;
      settle_sel_r <= sccs_pkg::SETTLE_SEL_RST;
    end else begin
      if (wr_main) begin
        hs_path_r  <= reg_wdata[sccs_pkg::BIT_HS_PATH];
        main_sel_r <= reg_wdata[sccs_pkg::BIT_MAIN_SEL];
      end
      if (wr_sset) begin
        settle_sel_r <= reg_wdata[2:0];
      end
    end
  end

  // prohibited codes leave the divider as it was
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      div_code_r <= sccs_pkg::CPU_DIV_RST;
    end else if (wr_cpu && (reg_wdata[2:0] <= sccs_pkg::CPU_DIV_MAX)) begin
      div_code_r <= reg_wdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // stop mode

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_mode_r <= 1'b0;
    end else if (stop_exec) begin
      stop_mode_r <= 1'b1;
    end else if (stop_release) begin
      stop_mode_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // internal oscillator model and accuracy settle

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_div_r <= 8'h0;
    end else if (!int_run || int_tick) begin
      int_div_r <= 8'h0;
    end else begin
      int_div_r <= int_div_r + 8'h1;
    end
  end

  // settled flag restarts from zero whenever the oscillator stops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_settle_r  <= 8'h0;
      int_settled_r <= 1'b0;
    end else if (!int_run) begin
      int_settle_r  <= 8'h0;
      int_settled_r <= 1'b0;
    end else if (int_settle_r == 8'(INT_SETTLE_CYC - 1)) begin
      int_settled_r <= 1'b1;
    end else begin
      int_settle_r  <= int_settle_r + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // high-speed clock edge and settle counter

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_prev_r <= 1'b0;
    end else begin
      hs_prev_r <= hs_clk_in & hs_run;
    end
  end

  // counts hs edges since start, saturating; software polls it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      settle_cnt_r <= 8'h0;
    end else if (!hs_run) begin
      settle_cnt_r <= 8'h0;
    end else if (hs_tick && (settle_cnt_r != 8'hff)) begin
      settle_cnt_r <= settle_cnt_r + 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // cpu clock hold after gain goes high

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_r <= 8'h0;
      hold_ext_r <= 1'b0;
    end else if (gain_rise) begin
      hold_ext_r <= ext_sel_r;
      hold_cnt_r <= ext_sel_r ? 8'(sccs_pkg::GAIN_HOLD_EXT_TICKS)
                              : 8'(sccs_pkg::GAIN_HOLD_CYC);
    end else if (hold_active && (!hold_ext_r || hs_tick)) begin
      hold_cnt_r <= hold_cnt_r - 8'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // main source switch, aligned to the target source's tick

  // switch happens on a tick of the new source, or at once to int if hs stops, so no pulse is cut
  always_comb begin
    ms_nxt = ms_r;
    unique case (ms_r)
      sccs_pkg::MS_INT:    if (want_hs) ms_nxt = sccs_pkg::MS_TO_HS;
      sccs_pkg::MS_TO_HS: begin
        if (!want_hs) ms_nxt = sccs_pkg::MS_INT;
        else if (hs_tick) ms_nxt = sccs_pkg::MS_HS;
      end
      sccs_pkg::MS_HS:     if (!want_hs) ms_nxt = sccs_pkg::MS_TO_INT;
      sccs_pkg::MS_TO_INT: begin
        if (want_hs) ms_nxt = sccs_pkg::MS_HS;
        else if (int_tick || !hs_run) ms_nxt = sccs_pkg::MS_INT;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ms_r <= sccs_pkg::MS_INT;
    end else begin
      ms_r <= ms_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // cpu divider; new ratio taken only at a cpu tick boundary

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_cnt_r <= 4'h0;
      div_act_r <= sccs_pkg::CPU_DIV_RST;
    end else if (ms_nxt != ms_r && (ms_nxt == sccs_pkg::MS_HS || ms_nxt == sccs_pkg::MS_INT)) begin
      cpu_cnt_r <= 4'h0;  // restart divider on the new source
    end else if (main_tick) begin
      cpu_cnt_r <= cpu_cnt_r + 4'h1;
      if (cpu_tick) begin
        div_act_r <= div_code_r;
        cpu_cnt_r <= 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registered outputs

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_en_r <= '0;
    end else begin
      clk_en_r.main_en   <= main_tick;
      clk_en_r.periph_en <= periph_tick;
      clk_en_r.cpu_en    <= cpu_tick & ~hold_active;
    end
  end

  // pin roles follow the two mode bits
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_ctl_r <= '{x1_port: 1'b1, x2_port: 1'b1, xtal_amp_en: 1'b0,
                     ext_in_en: 1'b0, gain_high: 1'b0};
    end else begin
      pin_ctl_r.x1_port     <= ~pin_mode_r | ext_sel_r;
      pin_ctl_r.x2_port     <= ~pin_mode_r;
      pin_ctl_r.xtal_amp_en <= pin_mode_r & ~ext_sel_r & hs_run;
      pin_ctl_r.ext_in_en   <= pin_mode_r & ext_sel_r & hs_run;
      pin_ctl_r.gain_high   <= gain_r;
    end
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= 8'h0;
    end else if (!reg_rd) begin
      rdata_r <= 8'h0;
    end else begin
      unique case (reg_addr)
        sccs_pkg::OFF_OSC_MODE:
          rdata_r <= {ext_sel_r, pin_mode_r, 5'h0, gain_r};
        sccs_pkg::OFF_HS_CTRL:    rdata_r <= {hs_stop_r, 7'h0};
        sccs_pkg::OFF_MAIN_MODE:
          rdata_r <= {2'h0, main_on_hs, 2'h0, hs_path_r, 1'b0, main_sel_r};
        sccs_pkg::OFF_CPU_CTRL:   rdata_r <= {5'h0, div_code_r};
        sccs_pkg::OFF_INT_MODE:   rdata_r <= {int_settled_r, 6'h0, int_stop_r};
        sccs_pkg::OFF_SETTLE_SEL: rdata_r <= {5'h0, settle_sel_r};
        sccs_pkg::OFF_SETTLE_CNT: rdata_r <= settle_cnt_r;
        default:                  rdata_r <= 8'h0;
      endcase
    end
  end

  assign reg_rdata          = rdata_r;
  assign clk_en             = clk_en_r;
  assign pin_ctl            = pin_ctl_r;
  assign settle_time_select = settle_sel_r;
  assign stop_mode          = stop_mode_r;

endmodule : sccs_clock_ctrl

`default_nettype wire

//--- pkg/sccs_pkg.sv
// sccs_pkg: register map, field positions, reset values, timing
// constants and carrier types for the system clock source control.
// assumes one 50 MHz system clock; all generated clocks are enables.
package sccs_pkg;

  // system clock rate
  localparam int unsigned CLK_MHZ = 50;

  // register offsets (byte addresses on the 8-bit register port)
  localparam logic [2:0] OFF_OSC_MODE  = 3'h0;
  localparam logic [2:0] OFF_HS_CTRL   = 3'h1;
  localparam logic [2:0] OFF_MAIN_MODE = 3'h2;
  localparam logic [2:0] OFF_CPU_CTRL  = 3'h3;
  localparam logic [2:0] OFF_INT_MODE  = 3'h4;
  localparam logic [2:0] OFF_SETTLE_SEL = 3'h5;
  localparam logic [2:0] OFF_SETTLE_CNT = 3'h6;

  // field positions
  localparam int unsigned BIT_EXT_SEL    = 7;  // osc_mode_reg
  localparam int unsigned BIT_PIN_MODE   = 6;  // osc_mode_reg
  localparam int unsigned BIT_GAIN       = 0;  // osc_mode_reg
  localparam int unsigned BIT_HS_STOP    = 7;  // hs_osc_ctrl_reg
  localparam int unsigned BIT_CPU_STAT   = 5;  // main_clk_mode_reg
  localparam int unsigned BIT_HS_PATH    = 2;  // main_clk_mode_reg
  localparam int unsigned BIT_MAIN_SEL   = 0;  // main_clk_mode_reg
  localparam int unsigned BIT_INT_SETTLED = 7; // int_osc_mode_reg
  localparam int unsigned BIT_INT_STOP   = 0;  // int_osc_mode_reg

  // reset values and divider limit
  localparam logic [2:0] CPU_DIV_RST   = 3'h1;  // divide by 2
  localparam logic [2:0] CPU_DIV_MAX   = 3'h4;  // divide by 16
  localparam logic [2:0] SETTLE_SEL_RST = 3'h5;

  // cpu clock hold after gain goes high, crystal case (least time, ns)
  localparam int unsigned GAIN_HOLD_NS = 4060;
  localparam int unsigned GAIN_HOLD_CYC = (GAIN_HOLD_NS * CLK_MHZ + 999) / 1000;
  // cpu clock hold after gain goes high, external clock case
  localparam int unsigned GAIN_HOLD_EXT_TICKS = 160;

  // main clock selection, gray coded along int -> hs -> int
  typedef enum logic [1:0] {
    MS_INT    = 2'b00,
    MS_TO_HS  = 2'b01,
    MS_HS     = 2'b11,
    MS_TO_INT = 2'b10
  } sccs_main_state_t;

  // clock enables handed to the rest of the chip
  typedef struct packed {
    logic main_en;
    logic periph_en;
    logic cpu_en;
  } sccs_clk_en_t;

  // state of the two high-speed clock pins
  typedef struct packed {
    logic x1_port;     // first pin is general i/o
    logic x2_port;     // second pin is general i/o
    logic xtal_amp_en; // crystal amplifier running
    logic ext_in_en;   // external clock input gate open
    logic gain_high;   // high-gain oscillator range
  } sccs_pin_ctl_t;

endpackage : sccs_pkg

//--- tb/sccs_hs_source.sv
// sccs_hs_source: crystal or external clock as seen at the high-speed pin.
// assumes ticks are made from sys_clk, never faster than half its rate.
`timescale 1ns/1ps
`default_nettype none

module sccs_hs_source (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       run,
  input  wire logic [3:0] half,
  output var  logic       hs_clk
);
  logic [3:0] cnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // toggles every half cycles; a halted oscillator rests low, no stale level
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= 4'h0;
      hs_clk <= 1'b0;
    end else if (!run) begin
      cnt_r  <= 4'h0;
      hs_clk <= 1'b0;
    end else if (cnt_r >= half - 4'h1) begin
      cnt_r  <= 4'h0;
      hs_clk <= ~hs_clk;
    end else begin
      cnt_r  <= cnt_r + 4'h1;
    end
  end
endmodule : sccs_hs_source
`default_nettype wire

//--- tb/sccs_clock_ctrl_sva.sv
// sccs_clock_ctrl_sva: port-level checks of the clock source control.
// assumes it is bound to sccs_clock_ctrl; one clock, async low reset.
`timescale 1ns/1ps
`default_nettype none

module sccs_clock_ctrl_sva #(
  parameter int unsigned INT_DIV        = 6,
  parameter int unsigned INT_SETTLE_CYC = 64
) (
  input wire logic                    sys_clk,
  input wire logic                    arst_n,
  input wire logic [2:0]              reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [7:0]              reg_rdata,
  input wire logic                    hs_clk_in,
  input wire logic                    stop_exec,
  input wire logic                    stop_release,
  input wire sccs_pkg::sccs_clk_en_t  clk_en,
  input wire sccs_pkg::sccs_pin_ctl_t pin_ctl,
  input wire logic [2:0]              settle_time_select,
  input wire logic                    stop_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  int unsigned hold_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // gain hold window, kept a few cycles short for phase slack
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) hold_cnt <= 0;
    else if ($rose(pin_ctl.gain_high)) hold_cnt <= sccs_pkg::GAIN_HOLD_CYC - 4;
    else if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
  end

  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read slot");
  unmapped_rd_a: assert property ($past(reg_rd) && $past(reg_addr) == 3'h7 |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  xtal_pins_a: assert property (pin_ctl.xtal_amp_en |->
    !pin_ctl.x1_port && !pin_ctl.x2_port)
    else $error("crystal running with pins in port use");
  ext_pins_a: assert property (pin_ctl.ext_in_en |->
    pin_ctl.x1_port && !pin_ctl.x2_port)
    else $error("external input with wrong pin use");
  stop_entry_a: assert property (stop_exec |=> stop_mode)
    else $error("stop not entered");
  stop_osc_off_a: assert property (stop_mode && $past(stop_mode) |->
    !pin_ctl.xtal_amp_en && !pin_ctl.ext_in_en)
    else $error("high-speed source alive in stop");
  stop_quiet_a: assert property (stop_mode && $past(stop_mode, 2) |-> clk_en == 3'b000)
    else $error("clock pulse while stopped");
  cpu_in_main_a: assert property (clk_en.cpu_en |-> clk_en.main_en)
    else $error("cpu pulse outside main pulse");
  main_pulse_a: assert property (clk_en.main_en |=> !clk_en.main_en)
    else $error("main pulse wider than one cycle");
  gain_hold_a: assert property (hold_cnt != 0 |-> !clk_en.cpu_en)
    else $error("cpu clocked during gain hold");
  settle_sel_a: assert property ($past(reg_wr) && $past(reg_addr) == 3'h5 |->
    settle_time_select == $past(reg_wdata[2:0]))
    else $error("settle select not stored");
endmodule : sccs_clock_ctrl_sva

bind sccs_clock_ctrl sccs_clock_ctrl_sva #(
  .INT_DIV(INT_DIV), .INT_SETTLE_CYC(INT_SETTLE_CYC)
) i_sva (
  .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hs_clk_in(hs_clk_in),
  .stop_exec(stop_exec), .stop_release(stop_release), .clk_en(clk_en), .pin_ctl(pin_ctl),
  .settle_time_select(settle_time_select), .stop_mode(stop_mode)
);
`default_nettype wire

//--- tb/tb_system_clock_source_control.sv
// tb_system_clock_source_control: register-driven tests of the clock control.
// assumes sccs_hs_source as far side and the bound port checker.
`timescale 1ns/1ps
`default_nettype none

module tb_system_clock_source_control;
  logic                    sys_clk = 1'b0;
  logic                    arst_n = 1'b0;
  logic [2:0]              reg_addr = 3'h0;
  logic [7:0]              reg_wdata = 8'h00;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic                    stop_exec = 1'b0;
  logic                    stop_release = 1'b0;
  logic [3:0]              hs_half = 4'h2;
  logic [7:0]              reg_rdata;
  logic                    hs_clk_in;
  sccs_pkg::sccs_clk_en_t  clk_en;
  sccs_pkg::sccs_pin_ctl_t pin_ctl;
  logic [2:0]              settle_time_select;
  logic                    stop_mode;
  logic [7:0]              d;
  int                      errors = 0;
  int                      n_compared = 0;
  int                      n_main = 0, n_per = 0, n_cpu = 0, m, p, c;

  always #10 sys_clk = ~sys_clk;

  sccs_clock_ctrl i_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hs_clk_in(hs_clk_in),
    .stop_exec(stop_exec), .stop_release(stop_release), .clk_en(clk_en), .pin_ctl(pin_ctl),
    .settle_time_select(settle_time_select), .stop_mode(stop_mode)
  );

  sccs_hs_source i_src (
    .sys_clk(sys_clk), .arst_n(arst_n), .run(pin_ctl.xtal_amp_en | pin_ctl.ext_in_en),
    .half(hs_half), .hs_clk(hs_clk_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pulse tallies, sampled before the design's updates land
  always @(posedge sys_clk) begin
    n_main += clk_en.main_en;
    n_per  += clk_en.periph_en;
    n_cpu  += clk_en.cpu_en;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd(input logic [2:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    chk({24'h0, d}, {24'h0, e});
  endtask : rdc

  // counts pulses over n edges; callers pick n as a multiple of the periods wherever a nonzero count is expected
  task automatic win(input int n);
    int m0, p0, c0;
    #1;
    m0 = n_main;
    p0 = n_per;
    c0 = n_cpu;
    repeat (n) @(posedge sys_clk);
    #1;
    m = n_main - m0;
    p = n_per - p0;
    c = n_cpu - c0;
  endtask : win

  task automatic do_reset();
    @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the full sequence needs well under 8000 cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    give_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    do_reset();
    chk(32'(pin_ctl), 32'h18);
    rdc(3'h1, 8'h80);
    rdc(3'h2, 8'h00);
    rdc(3'h3, 8'h01);
    rdc(3'h5, 8'h05);
    rdc(3'h7, 8'h00);
    wr(3'h0, 8'h01);
    win(190);
    chk(c, 0);
    chk(32'(pin_ctl.gain_high), 1);
    wr(3'h0, 8'h00);
    rdc(3'h0, 8'h01);
    repeat (60) @(posedge sys_clk);
    win(120);
    chk(m, 20);
    chk(c, 10);
    for (int k = 0; k <= 4; k++) begin
      wr(3'h3, 8'(k));
      repeat (200) @(posedge sys_clk);
      win(192);
      chk(c, 32 >> k);
    end
    wr(3'h3, 8'h05);
    rdc(3'h3, 8'h04);
    // crystal start; mode bits only change while stopped
    wr(3'h0, 8'h41);
    wr(3'h1, 8'h00);
    repeat (40) @(posedge sys_clk);
    chk(32'(pin_ctl), 32'h05);
    rd(3'h6);
    chk(32'(d != 8'h00), 1);
    rdc(3'h2, 8'h00);
    wr(3'h4, 8'h01);
    rdc(3'h4, 8'h80);
    wr(3'h2, 8'h05);
    repeat (20) @(posedge sys_clk);
    rdc(3'h2, 8'h25);
    win(200);
    chk(m, 50);
    chk(p, 50);
    wr(3'h1, 8'h80);
    rdc(3'h1, 8'h00);
    wr(3'h4, 8'h01);
    rd(3'h4);
    chk(32'(d[0]), 1);
    wr(3'h4, 8'h00);
    repeat (100) @(posedge sys_clk);
    rdc(3'h4, 8'h80);
    wr(3'h2, 8'h04);
    repeat (20) @(posedge sys_clk);
    rdc(3'h2, 8'h04);
    win(240);
    chk(m, 40);
    chk(p, 60);
    wr(3'h1, 8'h80);
    repeat (4) @(posedge sys_clk);
    chk(32'(pin_ctl.xtal_amp_en), 0);
    rdc(3'h6, 8'h00);
    // stop instruction with the crystal running
    wr(3'h1, 8'h00);
    wr(3'h5, 8'h03);
    // the stored value lands after the write edge, so look one edge later
    @(posedge sys_clk);
    chk(32'(settle_time_select), 3);
    @(posedge sys_clk);
    stop_exec <= 1'b1;
    @(posedge sys_clk);
    stop_exec <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(32'(stop_mode), 1);
    chk(32'(pin_ctl.xtal_amp_en), 0);
    win(60);
    chk(m, 0);
    @(posedge sys_clk);
    stop_release <= 1'b1;
    @(posedge sys_clk);
    stop_release <= 1'b0;
    repeat (30) @(posedge sys_clk);
    win(60);
    chk(m, 10);
    // second reset, slow external clock, gain raised while it runs
    do_reset();
    hs_half <= 4'h5;
    wr(3'h0, 8'hc0);
    wr(3'h1, 8'h00);
    repeat (4) @(posedge sys_clk);
    chk(32'(pin_ctl), 32'h12);
    wr(3'h0, 8'hc1);
    win(1500);
    chk(c, 0);
    repeat (300) @(posedge sys_clk);
    win(120);
    chk(c, 10);
    give_verdict();
  end
endmodule : tb_system_clock_source_control
`default_nettype wire
